/* design/scwcr_pkg.sv */
// Package of constants and types for the wake, clock and reset control bank
package scwcr_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_DBG = 12'h01C;
    localparam logic [11:0] OFF_WRISE = 12'h020;
    localparam logic [11:0] OFF_WFALL = 12'h024;
    localparam logic [11:0] OFF_WPEND = 12'h028;
    localparam logic [11:0] OFF_PDIV = 12'h038;
    localparam logic [11:0] OFF_LRST = 12'h040;
    localparam logic [11:0] OFF_HRST = 12'h050;
    localparam logic [11:0] OFF_LCEN = 12'h060;
    localparam logic [11:0] OFF_HCEN = 12'h070;
    localparam logic [11:0] OFF_DSTOP = 12'h080;
    localparam logic [11:0] OFF_ID = 12'h100;
    localparam logic [11:0] OFF_PWR = 12'h008;
    localparam logic [11:0] OFF_IMASK = 12'h02C;
    // Field positions and widths
    localparam int BIT_RTC_HALT = 4;
    localparam int BIT_DOG_HALT = 3;
    localparam int BIT_ALARM = 8;
    localparam int NUM_WAKE = 9;
    localparam int NUM_LSP = 29;
    localparam int NUM_HSP = 4;
    localparam int DIV_W = 4;
    // Cycles after reset until the event synchroniser stages hold real pin levels
    localparam logic [1:0] SYNC_FILL = 2'h3;
    // Low-power mode encoding
    localparam logic [1:0] LPM_STOP = 2'h1;
    // Peripherals allowed to stop in debug: watchdog, timers, GP timers, CAN
    localparam logic [28:0] DSTOP_ALLOWED = 29'h041FC002;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h00000000;

    // Register bus request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } scwcr_bus_t;

    // Power state
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_STOP = 2'b10
    } scwcr_pst_t;
endpackage

/* design/scwcr_top.sv */
// Wake, peripheral clock and reset control register bank
// What this block does
// - Debug bit 4 halts the real-time clock counting while the core is in debug.
// - Debug bit 3 halts the independent watchdog while the core is in debug.
// - Rising-select bits 7..0 let a rising edge on irq line 0..7 wake from stop.
// - Falling-select bits 7..0 let a falling edge on irq line 0..7 wake from stop.
// - Bit 8 of either select register lets the alarm event wake from stop.
// - Each enabled source sets its wake-pending bit when its event occurs.
// - The peripheral bus clock is the system clock divided by field plus one.
// - Low-speed reset bits 0..28 hold their peripheral in reset while one.
// - High-speed reset bits 0..3 hold DMA, USB, checksum and MAC in reset.
// - Low-speed clock enables gate peripheral clocks by the reset bit layout.
// - High-speed clock enables gate peripheral clocks by the reset bit layout.
// - Debug clock stop exists only for watchdog, timers, GP timers and CAN.
// - A debug-stop bit of one stops that clock in debug; zero keeps it running.
// - The identity register returns a fixed code and ignores writes.
// - Stop mode is entered on wait-for-interrupt while the power field is one.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module scwcr_top import scwcr_pkg::*; #(
    parameter logic [31:0] CHIP_ID = 32'h0000C0DE // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Core and event inputs
    input wire logic debug_i,
    input wire logic wfi_i,
    input wire logic [7:0] external_irq_lines_i,
    input wire logic alarm_i,
    // Control outputs
    output logic halt_rtc_o,
    output logic halt_dog_o,
    output logic stop_mode_o,
    output logic pclk_en_o,
    output logic [NUM_LSP-1:0] lsp_rst_o,
    output logic [NUM_HSP-1:0] hsp_rst_o,
    output logic [NUM_LSP-1:0] lsp_clk_en_o,
    output logic [NUM_HSP-1:0] hsp_clk_en_o,
    output logic irq_o
);
    typedef struct packed {
        logic [31:0] rdata;
        logic [1:0] dbg;
        logic [NUM_WAKE-1:0] rise;
        logic [NUM_WAKE-1:0] fall;
        logic [NUM_WAKE-1:0] pend;
        logic [NUM_WAKE-1:0] imask;
        logic [DIV_W-1:0] div;
        logic [DIV_W-1:0] divcnt;
        logic [1:0] lpm;
        logic [NUM_LSP-1:0] lrst;
        logic [NUM_HSP-1:0] hrst;
        logic [NUM_LSP-1:0] lcen;
        logic [NUM_HSP-1:0] hcen;
        logic [NUM_LSP-1:0] dstop;
        logic [NUM_WAKE-1:0] s1;
        logic [NUM_WAKE-1:0] s2;
        logic [NUM_WAKE-1:0] s3;
        logic [NUM_WAKE-1:0] evq;
        logic [1:0] warm;
        logic dbg1;
        logic dbg2;
        logic dbg3;
        logic dbgq;
        scwcr_pst_t pst;
        logic halt_rtc;
        logic halt_dog;
        logic pclk_en;
        logic [NUM_LSP-1:0] lrst_o;
        logic [NUM_HSP-1:0] hrst_o;
        logic [NUM_LSP-1:0] lclk_o;
        logic [NUM_HSP-1:0] hclk_o;
        logic irq;
    } scwcr_st_t;

    scwcr_st_t r;
    scwcr_st_t next_r;
    logic [NUM_WAKE-1:0] rise_ev;
    logic [NUM_WAKE-1:0] fall_ev;
    logic [NUM_WAKE-1:0] wake_ev;
    logic [NUM_WAKE-1:0] pend_clr;

    // Address match helper for the register port
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // Edge events on the filtered level; a change counts once stages two and three agree
    assign rise_ev = (r.warm == SYNC_FILL) ? (r.s2 & r.s3 & ~r.evq) : '0;
    assign fall_ev = (r.warm == SYNC_FILL) ? (~r.s2 & ~r.s3 & r.evq) : '0;
    assign wake_ev = (rise_ev & r.rise) | (fall_ev & r.fall);
    assign pend_clr = (wr_i && hit(addr_i, OFF_WPEND)) ? wdata_i[NUM_WAKE-1:0] : '0;

    // Next-state logic for all registers
    always_comb begin
        next_r = r;
        // Three-stage sampling of pins and the debug level
        next_r.s1 = {alarm_i, external_irq_lines_i};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.dbg1 = debug_i;
        next_r.dbg2 = r.dbg1;
        next_r.dbg3 = r.dbg2;
        if (r.dbg2 == r.dbg3) begin
            next_r.dbgq = r.dbg2;
        end
        // Filtered event level; while the stages fill it just follows, so a pin
        // idling high gives no false edge after reset
        if (r.warm != SYNC_FILL) begin
            next_r.warm = r.warm + 2'h1;
            next_r.evq = r.s2;
        end else begin
            next_r.evq = (r.s2 & r.s3) | (r.evq & (r.s2 | r.s3));
        end
        // Set wins over a same-cycle clear
        next_r.pend = (r.pend & ~pend_clr) | wake_ev;
        // Register writes
        if (wr_i) begin
            if (hit(addr_i, OFF_DBG)) begin
                next_r.dbg = wdata_i[BIT_RTC_HALT:BIT_DOG_HALT];
            end else if (hit(addr_i, OFF_WRISE)) begin
                next_r.rise = wdata_i[NUM_WAKE-1:0];
            end else if (hit(addr_i, OFF_WFALL)) begin
                next_r.fall = wdata_i[NUM_WAKE-1:0];
            end else if (hit(addr_i, OFF_IMASK)) begin
                next_r.imask = wdata_i[NUM_WAKE-1:0];
            end else if (hit(addr_i, OFF_PDIV)) begin
                next_r.div = wdata_i[DIV_W-1:0];
            end else if (hit(addr_i, OFF_PWR)) begin
                next_r.lpm = wdata_i[1:0];
            end else if (hit(addr_i, OFF_LRST)) begin
                next_r.lrst = wdata_i[NUM_LSP-1:0];
            end else if (hit(addr_i, OFF_HRST)) begin
                next_r.hrst = wdata_i[NUM_HSP-1:0];
            end else if (hit(addr_i, OFF_LCEN)) begin
                next_r.lcen = wdata_i[NUM_LSP-1:0];
            end else if (hit(addr_i, OFF_HCEN)) begin
                next_r.hcen = wdata_i[NUM_HSP-1:0];
            end else if (hit(addr_i, OFF_DSTOP)) begin
                next_r.dstop = wdata_i[NUM_LSP-1:0] & DSTOP_ALLOWED;
            end
            // Identity and unmapped writes fall through unchanged
        end
        // Read data valid only in the cycle after the strobe
        next_r.rdata = RST_ZERO;
        if (rd_i) begin
            if (hit(addr_i, OFF_DBG)) begin
                next_r.rdata = {27'h0, r.dbg, 3'h0};
            end else if (hit(addr_i, OFF_WRISE)) begin
                next_r.rdata = {23'h0, r.rise};
            end else if (hit(addr_i, OFF_WFALL)) begin
                next_r.rdata = {23'h0, r.fall};
            end else if (hit(addr_i, OFF_WPEND)) begin
                next_r.rdata = {23'h0, r.pend};
            end else if (hit(addr_i, OFF_IMASK)) begin
                next_r.rdata = {23'h0, r.imask};
            end else if (hit(addr_i, OFF_PDIV)) begin
                next_r.rdata = {28'h0, r.div};
            end else if (hit(addr_i, OFF_PWR)) begin
                next_r.rdata = {30'h0, r.lpm};
            end else if (hit(addr_i, OFF_LRST)) begin
                next_r.rdata = {3'h0, r.lrst};
            end else if (hit(addr_i, OFF_HRST)) begin
                next_r.rdata = {28'h0, r.hrst};
            end else if (hit(addr_i, OFF_LCEN)) begin
                next_r.rdata = {3'h0, r.lcen};
            end else if (hit(addr_i, OFF_HCEN)) begin
                next_r.rdata = {28'h0, r.hcen};
            end else if (hit(addr_i, OFF_DSTOP)) begin
                next_r.rdata = {3'h0, r.dstop};
            end else if (hit(addr_i, OFF_ID)) begin
                next_r.rdata = CHIP_ID;
            end
        end
        // Peripheral bus clock enable: one pulse every div+1 cycles
        if (r.divcnt >= r.div) begin
            next_r.divcnt = '0;
            next_r.pclk_en = 1'b1;
        end else begin
            next_r.divcnt = r.divcnt + 4'h1;
            next_r.pclk_en = 1'b0;
        end
        // Power state
        case (r.pst)
            ST_RUN: begin
                if (wfi_i && r.lpm == LPM_STOP) begin
                    next_r.pst = ST_STOP;
                end
            end
            ST_STOP: begin
                if (|r.pend) begin
                    next_r.pst = ST_RUN;
                end
            end
            default: begin
                next_r.pst = ST_RUN;
            end
        endcase
        // Debug halts and clock gating
        next_r.halt_rtc = r.dbgq & r.dbg[1];
        next_r.halt_dog = r.dbgq & r.dbg[0];
        next_r.lrst_o = r.lrst;
        next_r.hrst_o = r.hrst;
        next_r.lclk_o = r.lcen & ~({NUM_LSP{r.dbgq}} & r.dstop);
        next_r.hclk_o = r.hcen;
        next_r.irq = |(r.pend & r.imask);
    end

    // State register; stop mode is held only in the clock-domain view
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r <= '0;
            r.pst <= ST_RUN;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_o = r.rdata;
    assign halt_rtc_o = r.halt_rtc;
    assign halt_dog_o = r.halt_dog;
    assign stop_mode_o = r.pst[1]; // One-hot stop bit of the state flop
    assign pclk_en_o = r.pclk_en;
    assign lsp_rst_o = r.lrst_o;
    assign hsp_rst_o = r.hrst_o;
    assign lsp_clk_en_o = r.lclk_o;
    assign hsp_clk_en_o = r.hclk_o;
    assign irq_o = r.irq;
endmodule

/* verification/scwcr_top_asserts.sv */
// Port assertions for the wake, clock and reset control bank
`timescale 1ns/1ps
module scwcr_top_asserts import scwcr_pkg::*; #(
    parameter logic [31:0] CHIP_ID = 32'h0000C0DE // Arbitrary value
) (
    // Clock, reset and register port
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [11:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // Core inputs and control outputs
    input wire logic debug_i,
    input wire logic wfi_i,
    input wire logic halt_rtc_o,
    input wire logic halt_dog_o,
    input wire logic stop_mode_o,
    input wire logic [NUM_LSP-1:0] lsp_rst_o,
    input wire logic [NUM_HSP-1:0] hsp_rst_o,
    input wire logic [NUM_LSP-1:0] lsp_clk_en_o,
    input wire logic [NUM_HSP-1:0] hsp_clk_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // A read of the identity word, answered one cycle later
    sequence s_id_read;
        rd_i && addr_i == OFF_ID;
    endsequence
    // Debug long settled low, so filter delay is already spent
    sequence s_debug_quiet;
        !debug_i [*8];
    endsequence
    a_id_value: assert property (s_id_read |=> rdata_o == CHIP_ID)
        else $error("identity read wrong");
    a_rdata_quiet: assert property (!rd_i |=> rdata_o == 32'h00000000)
        else $error("read data outside read cycle");
    a_stop_cause: assert property ($rose(stop_mode_o) |-> $past(wfi_i))
        else $error("stop without wait request");
    a_lrst_cause: assert property ($changed(lsp_rst_o) |-> $past(wr_i && addr_i == OFF_LRST, 2))
        else $error("low-speed reset moved without write");
    a_hrst_cause: assert property ($changed(hsp_rst_o) |-> $past(wr_i && addr_i == OFF_HRST, 2))
        else $error("high-speed reset moved without write");
    a_hcen_cause: assert property ($changed(hsp_clk_en_o) |-> $past(wr_i && addr_i == OFF_HCEN, 2))
        else $error("high-speed enable moved without write");
    a_halt_idle: assert property (s_debug_quiet |-> !halt_rtc_o && !halt_dog_o)
        else $error("halt raised outside debug");
    a_lcen_idle: assert property ((s_debug_quiet ##0 $changed(lsp_clk_en_o)) |-> $past(wr_i && addr_i == OFF_LCEN, 2))
        else $error("low-speed enable moved without write");
endmodule
bind scwcr_top scwcr_top_asserts #(.CHIP_ID(CHIP_ID)) i_scwcr_top_asserts (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .debug_i(debug_i), .wfi_i(wfi_i), .halt_rtc_o(halt_rtc_o), .halt_dog_o(halt_dog_o), .stop_mode_o(stop_mode_o), .lsp_rst_o(lsp_rst_o), .hsp_rst_o(hsp_rst_o), .lsp_clk_en_o(lsp_clk_en_o), .hsp_clk_en_o(hsp_clk_en_o));

/* verification/scwcr_top_bench.sv */
// Self-checking bench for the wake, clock and reset control bank
`timescale 1ns/1ps
module scwcr_top_bench import scwcr_pkg::*;;
    localparam logic [31:0] ID = 32'h0000BEEF; // Arbitrary value
    localparam logic [11:0] OFFS [0:8] = '{OFF_DBG, OFF_WRISE, OFF_WFALL, OFF_PDIV, OFF_LRST,
        OFF_HRST, OFF_LCEN, OFF_HCEN, OFF_DSTOP};
    localparam logic [31:0] MSK [0:8] = '{32'h18, 32'h1FF, 32'h1FF, 32'hF, 32'h1FFFFFFF, 32'hF,
        32'h1FFFFFFF, 32'hF, 32'h041FC002};
    logic clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, debug_i = 1'b0, wfi_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h00000000, rdata_o, seed = 32'h00000016;
    logic [8:0] src = 9'h000;
    logic halt_rtc_o, halt_dog_o, stop_mode_o, pclk_en_o, irq_o;
    logic [NUM_LSP-1:0] lsp_rst_o, lsp_clk_en_o;
    logic [NUM_HSP-1:0] hsp_rst_o, hsp_clk_en_o;
    logic [31:0] regv [0:8];
    int err_total = 0;
    int n_checks = 0;
    scwcr_top #(.CHIP_ID(ID)) i_scwcr_top (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .debug_i(debug_i),
        .wfi_i(wfi_i), .external_irq_lines_i(src[7:0]), .alarm_i(src[8]), .halt_rtc_o(halt_rtc_o),
        .halt_dog_o(halt_dog_o), .stop_mode_o(stop_mode_o), .pclk_en_o(pclk_en_o),
        .lsp_rst_o(lsp_rst_o), .hsp_rst_o(hsp_rst_o), .lsp_clk_en_o(lsp_clk_en_o),
        .hsp_clk_en_o(hsp_clk_en_o), .irq_o(irq_o));
    // Repeatable xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe; a gap cycle follows so strobes never merge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // Whole run needs well under this many cycles
    initial begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        finish_test();
    end
    initial begin
        logic [31:0] v;
        int cnt;
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 9; i++) rd(OFFS[i], 32'h0);
        wr(OFF_ID, 32'hFFFFFFFF);
        rd(OFF_ID, ID);
        rd(12'h0FC, 32'h0);
        $display("Test reset and identity done");
        // Random contents, then outputs with debug off and on
        repeat (12) begin
            for (int i = 0; i < 9; i++) begin
                v = xs();
                regv[i] = v & MSK[i];
                wr(OFFS[i], v);
            end
            for (int i = 0; i < 9; i++) rd(OFFS[i], regv[i]);
            repeat (2) @(posedge clk_i);
            #1 chk({3'h0, lsp_rst_o}, regv[4]);
            chk({28'h0, hsp_rst_o}, regv[5]);
            chk({3'h0, lsp_clk_en_o}, regv[6]);
            chk({28'h0, hsp_clk_en_o}, regv[7]);
            @(posedge clk_i);
            debug_i <= 1'b1;
            repeat (8) @(posedge clk_i);
            #1 chk({30'h0, halt_rtc_o, halt_dog_o}, {30'h0, regv[0][4], regv[0][3]});
            chk({3'h0, lsp_clk_en_o}, regv[6] & ~regv[8]);
            @(posedge clk_i);
            debug_i <= 1'b0;
            repeat (8) @(posedge clk_i);
        end
        $display("Test registers and debug done");
        // Divider settings 0, 5, 10 and 15: 16 periods hold 16 enable pulses
        for (int d = 0; d < 16; d += 5) begin
            wr(OFF_PDIV, d);
            repeat (4) @(posedge clk_i);
            cnt = 0;
            repeat (16 * (d + 1)) begin
                @(posedge clk_i);
                #1 cnt += pclk_en_o;
            end
            chk(cnt, 16);
        end
        $display("Test divider done");
        // Wait request with the power field still zero must not stop
        @(posedge clk_i);
        wfi_i <= 1'b1;
        @(posedge clk_i);
        wfi_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk(stop_mode_o, 1'b0);
        // Each source, rising then falling, masked on the falling pass
        wr(OFF_PWR, {30'h0, LPM_STOP});
        rd(OFF_PWR, {30'h0, LPM_STOP});
        for (int i = 0; i < 9; i++) begin
            for (int e = 0; e < 2; e++) begin
                v = 32'h1 << i;
                wr(OFF_WRISE, e ? 32'h0 : v);
                wr(OFF_WFALL, e ? v : 32'h0);
                wr(OFF_IMASK, e ? 32'h0 : v);
                @(posedge clk_i);
                wfi_i <= 1'b1;
                @(posedge clk_i);
                wfi_i <= 1'b0;
                @(posedge clk_i);
                #1 chk(stop_mode_o, 1'b1);
                @(posedge clk_i);
                src[i] <= ~src[i];
                repeat (8) @(posedge clk_i);
                rd(OFF_WPEND, v);
                chk({stop_mode_o, irq_o}, {1'b0, e == 0});
                wr(OFF_WPEND, v);
                rd(OFF_WPEND, 32'h0);
            end
        end
        $display("Test wake sources done");
        finish_test();
    end
endmodule
